// ### src/data_ram_256.sv
// Byte-wide RAM of the whole data memory with one synchronous port
`timescale 1ns/100ps
module data_ram_256 (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       we_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o
);

    logic [7:0] mem [idm_pkg::RAM_DEPTH];

    // Storage has no reset, as a real RAM; only the read register is cleared
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= mem[addr_i];
        end
    end

endmodule : data_ram_256

// ### src/idm_pkg.sv
// Shared constants, types and helpers for the internal data memory decoder
package idm_pkg;

    // Special function space addresses held inside this block
    localparam logic [7:0] ADDR_SP          = 8'h81;
    localparam logic [7:0] ADDR_PSW         = 8'hD0;
    localparam logic [7:0] ADDR_ACC         = 8'hE0;
    localparam logic [7:0] ADDR_B           = 8'hF0;

    // Values after reset
    localparam logic [7:0] RESET_SP         = 8'h07;
    localparam logic [7:0] RESET_PSW        = 8'h00;
    localparam logic [7:0] RESET_ACC        = 8'h00;
    localparam logic [7:0] RESET_B          = 8'h00;

    // Memory layout
    localparam int         RAM_DEPTH        = 256;
    localparam logic [7:0] DIRECT_RAM_TOP   = 8'h7F;
    localparam logic [7:0] BIT_AREA_BASE    = 8'h20;
    localparam int         BANK_SEL_LOW_POS = 3;
    localparam int         BANK_SEL_HI_POS  = 4;

    typedef enum logic [1:0] {
        SPACE_RAM,
        SPACE_LOCAL,
        SPACE_EXT
    } space_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PTR,
        ST_ACCESS,
        ST_READ
    } state_e;

    typedef struct packed {
        state_e     state;
        logic [7:0] sp;
        logic [7:0] program_status_word;
        logic [7:0] acc;
        logic [7:0] b;
        logic [7:0] tgt;
        logic [2:0] pos;
        space_e     space;
        logic       isbit;
        logic       wr;
        logic       wbit;
        logic [7:0] wdata;
        logic       busy;
        logic       ack;
        logic [7:0] rdata;
        logic       rbit;
        logic       sfr_req;
        logic       sfr_wr;
        logic [7:0] sfr_addr;
        logic [7:0] sfr_wdata;
    } state_s;

    // Byte address that holds a given bit address
    function automatic logic [7:0] bit_byte(input logic [7:0] bit_addr);
        if (bit_addr <= DIRECT_RAM_TOP) begin
            bit_byte = 8'(BIT_AREA_BASE + {4'h0, bit_addr[6:3]});
        end else begin
            bit_byte = {bit_addr[7:3], 3'b000};
        end
    endfunction : bit_byte

    // Space reached by a direct address
    function automatic space_e direct_space(input logic [7:0] addr);
        if (addr <= DIRECT_RAM_TOP) begin
            direct_space = SPACE_RAM;
        end else if (addr == ADDR_SP || addr == ADDR_PSW ||
                     addr == ADDR_ACC || addr == ADDR_B) begin
            direct_space = SPACE_LOCAL;
        end else begin
            direct_space = SPACE_EXT;
        end
    endfunction : direct_space

endpackage : idm_pkg

// ### src/internal_data_memory_decoder.sv
// Internal data memory with address decoding, register banks and stack pointer
`timescale 1ns/100ps
module internal_data_memory_decoder (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       req_i,
    input  wire logic       wr_i,
    input  wire logic       indirect_i,
    input  wire logic       bit_i,
    input  wire logic       ptr_sel_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wbit_i,
    input  wire logic       push_i,
    input  wire logic       pop_i,
    input  wire logic [7:0] sfr_rdata_i,
    output logic            ack_o,
    output logic      [7:0] rdata_o,
    output logic            rbit_o,
    output logic            busy_o,
    output logic            sfr_req_o,
    output logic            sfr_wr_o,
    output logic      [7:0] sfr_addr_o,
    output logic      [7:0] sfr_wdata_o,
    output logic      [7:0] stack_top_pointer_o,
    output logic      [7:0] program_status_word_o,
    output logic      [7:0] accumulator_reg_o,
    output logic      [7:0] b_reg_o,
    output logic      [1:0] bank_o
);

    localparam idm_pkg::state_s RESET_ST = '{
        state:     idm_pkg::ST_IDLE,
        sp:        idm_pkg::RESET_SP,
        program_status_word:       idm_pkg::RESET_PSW,
        acc:       idm_pkg::RESET_ACC,
        b:         idm_pkg::RESET_B,
        tgt:       8'h00,
        pos:       3'h0,
        space:     idm_pkg::SPACE_RAM,
        isbit:     1'b0,
        wr:        1'b0,
        wbit:      1'b0,
        wdata:     8'h00,
        busy:      1'b0,
        ack:       1'b0,
        rdata:     8'h00,
        rbit:      1'b0,
        sfr_req:   1'b0,
        sfr_wr:    1'b0,
        sfr_addr:  8'h00,
        sfr_wdata: 8'h00
    };

    idm_pkg::state_s st;
    idm_pkg::state_s next_st;

    logic       ram_we;
    logic [7:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_rdata;
    logic       do_wr;
    logic       do_rd;
    logic [7:0] wr_val;
    logic [7:0] rd_val;
    logic [1:0] bank;
    logic [7:0] bit_tgt;

    // One RAM for all 256 bytes; special registers are kept elsewhere
    data_ram_256 u_ram (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .we_i    (ram_we),
        .addr_i  (ram_addr),
        .wdata_i (ram_wdata),
        .rdata_o (ram_rdata)
    );

    // Active bank from the two bank-select bits of the status word
    assign bank = {st.program_status_word[idm_pkg::BANK_SEL_HI_POS],
                   st.program_status_word[idm_pkg::BANK_SEL_LOW_POS]};
    assign bit_tgt = idm_pkg::bit_byte(addr_i);

    // Byte seen by the second phase of a read, from the space it lives in
    always_comb begin
        case (st.space)
            idm_pkg::SPACE_RAM: begin
                rd_val = ram_rdata;
            end
            idm_pkg::SPACE_EXT: begin
                rd_val = sfr_rdata_i;
            end
            default: begin
                case (st.tgt)
                    idm_pkg::ADDR_SP:  rd_val = st.sp;
                    idm_pkg::ADDR_PSW: rd_val = st.program_status_word;
                    idm_pkg::ADDR_ACC: rd_val = st.acc;
                    idm_pkg::ADDR_B:   rd_val = st.b;
                    default:           rd_val = 8'h00;
                endcase
            end
        endcase
    end

    // Sequencer: push beats pop beats a plain access; one job at a time
    always_comb begin
        next_st = st;
        ram_we = 1'b0;
        ram_addr = 8'h00;
        ram_wdata = 8'h00;
        do_wr = 1'b0;
        do_rd = 1'b0;
        wr_val = 8'h00;
        next_st.ack = 1'b0;
        next_st.sfr_req = 1'b0;
        next_st.sfr_wr = 1'b0;
        case (st.state)
            idm_pkg::ST_IDLE: begin
                if (push_i) begin
                    // Write lands above the last used byte, then pointer moves
                    ram_we = 1'b1;
                    ram_addr = 8'(st.sp + 8'h01);
                    ram_wdata = wdata_i;
                    next_st.sp = 8'(st.sp + 8'h01);
                    next_st.ack = 1'b1;
                end else if (pop_i) begin
                    ram_addr = st.sp;
                    next_st.sp = 8'(st.sp - 8'h01);
                    next_st.space = idm_pkg::SPACE_RAM;
                    next_st.tgt = st.sp;
                    next_st.wr = 1'b0;
                    next_st.isbit = 1'b0;
                    next_st.pos = 3'h0;
                    next_st.busy = 1'b1;
                    next_st.state = idm_pkg::ST_READ;
                end else if (req_i) begin
                    next_st.wr = wr_i;
                    next_st.wbit = wbit_i;
                    next_st.wdata = wdata_i;
                    next_st.isbit = bit_i;
                    next_st.busy = 1'b1;
                    if (bit_i) begin
                        // Bit operands are always direct
                        next_st.tgt = bit_tgt;
                        next_st.pos = addr_i[2:0];
                        next_st.space = idm_pkg::direct_space(bit_tgt);
                        next_st.state = idm_pkg::ST_ACCESS;
                    end else if (indirect_i) begin
                        // Fetch the index register of the active bank first
                        ram_addr = {3'b000, bank, 2'b00, ptr_sel_i};
                        next_st.state = idm_pkg::ST_PTR;
                    end else begin
                        next_st.tgt = addr_i;
                        next_st.pos = 3'h0;
                        next_st.space = idm_pkg::direct_space(addr_i);
                        next_st.state = idm_pkg::ST_ACCESS;
                    end
                end
            end
            idm_pkg::ST_PTR: begin
                // Indirect targets are RAM across the whole range
                next_st.tgt = ram_rdata;
                next_st.space = idm_pkg::SPACE_RAM;
                next_st.state = idm_pkg::ST_ACCESS;
            end
            idm_pkg::ST_ACCESS: begin
                if (st.wr && !st.isbit) begin
                    do_wr = 1'b1;
                    wr_val = st.wdata;
                end else begin
                    // Bit writes read the byte first to keep its other bits
                    do_rd = 1'b1;
                    next_st.state = idm_pkg::ST_READ;
                end
            end
            idm_pkg::ST_READ: begin
                if (st.wr) begin
                    do_wr = 1'b1;
                    wr_val = rd_val;
                    wr_val[st.pos] = st.wbit;
                end else begin
                    next_st.rdata = rd_val;
                    next_st.rbit = rd_val[st.pos];
                    next_st.ack = 1'b1;
                    next_st.busy = 1'b0;
                    next_st.state = idm_pkg::ST_IDLE;
                end
            end
            default: begin
                next_st.busy = 1'b0;
                next_st.state = idm_pkg::ST_IDLE;
            end
        endcase

        // Write to whichever space the target lives in
        if (do_wr) begin
            next_st.ack = 1'b1;
            next_st.busy = 1'b0;
            next_st.state = idm_pkg::ST_IDLE;
            case (st.space)
                idm_pkg::SPACE_RAM: begin
                    ram_we = 1'b1;
                    ram_addr = st.tgt;
                    ram_wdata = wr_val;
                end
                idm_pkg::SPACE_LOCAL: begin
                    case (st.tgt)
                        idm_pkg::ADDR_SP:  next_st.sp = wr_val;
                        idm_pkg::ADDR_PSW: next_st.program_status_word = wr_val;
                        idm_pkg::ADDR_ACC: next_st.acc = wr_val;
                        idm_pkg::ADDR_B:   next_st.b = wr_val;
                        default:           next_st.b = st.b;
                    endcase
                end
                default: begin
                    // Unoccupied addresses are passed on as they are
                    next_st.sfr_req = 1'b1;
                    next_st.sfr_wr = 1'b1;
                    next_st.sfr_addr = st.tgt;
                    next_st.sfr_wdata = wr_val;
                end
            endcase
        end

        // Start a read; local registers need no request
        if (do_rd) begin
            case (st.space)
                idm_pkg::SPACE_RAM: begin
                    ram_addr = st.tgt;
                end
                idm_pkg::SPACE_EXT: begin
                    next_st.sfr_req = 1'b1;
                    next_st.sfr_addr = st.tgt;
                end
                default: begin
                    ram_addr = 8'h00;
                end
            endcase
        end
    end

    // State register with synchronous active-low reset
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st <= RESET_ST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign ack_o                 = st.ack;
    assign rdata_o               = st.rdata;
    assign rbit_o                = st.rbit;
    assign busy_o                = st.busy;
    assign sfr_req_o             = st.sfr_req;
    assign sfr_wr_o              = st.sfr_wr;
    assign sfr_addr_o            = st.sfr_addr;
    assign sfr_wdata_o           = st.sfr_wdata;
    assign stack_top_pointer_o   = st.sp;
    assign program_status_word_o = st.program_status_word;
    assign accumulator_reg_o     = st.acc;
    assign b_reg_o               = st.b;
    assign bank_o                = bank; // Bits of st.program_status_word, no logic between

endmodule : internal_data_memory_decoder

// ### verification/idm_sfr_model.sv
// Behavioural model of the external special function space
`timescale 1ns/100ps
module idm_sfr_model (
    input  wire logic       clk_i,
    input  wire logic       sfr_req_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o
);
    logic [7:0] mem [256];
    logic [7:0] last;

    // Each location starts out holding its own address
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i);
        end
        last = 8'h00;
    end

    // Writes land on the pulse; idle bus shows the inverse of the last value
    always @(posedge clk_i) begin
        if (sfr_req_i && sfr_wr_i) begin
            mem[sfr_addr_i] <= sfr_wdata_i;
        end
        last <= sfr_rdata_o;
    end

    // Read data only during a read pulse, so a late sample shows garbage
    assign sfr_rdata_o = (sfr_req_i && !sfr_wr_i) ? mem[sfr_addr_i] : ~last;
endmodule : idm_sfr_model

// ### verification/internal_data_memory_decoder_monitor.sv
// Port checker for the internal data memory decoder
`timescale 1ns/100ps
module internal_data_memory_decoder_monitor (
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic       req_i,
    input wire logic       indirect_i,
    input wire logic       bit_i,
    input wire logic [7:0] addr_i,
    input wire logic       push_i,
    input wire logic       pop_i,
    input wire logic       ack_o,
    input wire logic       busy_o,
    input wire logic       sfr_req_o,
    input wire logic       sfr_wr_o,
    input wire logic [7:0] sfr_addr_o,
    input wire logic [7:0] stack_top_pointer_o,
    input wire logic [7:0] program_status_word_o,
    input wire logic [7:0] accumulator_reg_o,
    input wire logic [7:0] b_reg_o,
    input wire logic [1:0] bank_o
);
    logic       take;
    logic [7:0] bbyte;
    logic       loc;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Accepted access, byte holding a bit above 7F, locally held byte addresses
    assign take  = req_i && !busy_o && !push_i && !pop_i;
    assign bbyte = {addr_i[7:3], 3'h0};
    assign loc   = addr_i == 8'h81 || addr_i == 8'hD0 || addr_i == 8'hE0 || addr_i == 8'hF0;

    a_reset_values: assert property ($rose(nrst_i) |-> stack_top_pointer_o == 8'h07
        && accumulator_reg_o == 8'h00 && b_reg_o == 8'h00) else $error("bad reset values");
    a_bank_follows: assert property (bank_o == program_status_word_o[4:3])
        else $error("bank select not from status bits");
    a_push_incr: assert property (push_i && !busy_o |=> ack_o
        && stack_top_pointer_o == 8'($past(stack_top_pointer_o) + 8'h01))
        else $error("push did not advance pointer");
    a_pop_decr: assert property (pop_i && !push_i && !busy_o |=> busy_o ##1 ack_o
        && stack_top_pointer_o == 8'($past(stack_top_pointer_o, 2) - 8'h01))
        else $error("pop did not retreat pointer");
    a_direct_sfr: assert property (take && !bit_i && !indirect_i && addr_i[7] && !loc
        |-> ##2 sfr_req_o && sfr_addr_o == $past(addr_i, 2)) else $error("direct high not to sfr");
    a_indirect_ram: assert property (take && !bit_i && indirect_i |=> !sfr_req_o [*4])
        else $error("indirect access leaked to sfr");
    a_low_ram: assert property (take && !bit_i && !addr_i[7] |=> !sfr_req_o [*3])
        else $error("low direct access leaked to sfr");
    a_bit_done: assert property (take && bit_i |-> ##3 ack_o)
        else $error("bit access not done in three cycles");
    a_bit_sfr: assert property (take && bit_i && addr_i[7]
        && !(bbyte inside {8'hD0, 8'hE0, 8'hF0})
        |-> ##2 sfr_req_o && !sfr_wr_o && sfr_addr_o == $past(bbyte, 2))
        else $error("sfr bit not read from its byte");

    // Main scenarios reached
    c_push: cover property (push_i && !busy_o ##1 push_i);
    c_pop: cover property (pop_i && !busy_o);
    c_bit_sfr: cover property (take && bit_i && addr_i[7]);
endmodule : internal_data_memory_decoder_monitor

bind internal_data_memory_decoder internal_data_memory_decoder_monitor u_monitor (
    .clk_i, .nrst_i, .req_i, .indirect_i, .bit_i, .addr_i, .push_i, .pop_i, .ack_o,
    .busy_o, .sfr_req_o, .sfr_wr_o, .sfr_addr_o, .stack_top_pointer_o,
    .program_status_word_o, .accumulator_reg_o, .b_reg_o, .bank_o
);

// ### verification/internal_data_memory_decoder_tb.sv
// Self-checking bench for the internal data memory decoder
`timescale 1ns/100ps
module internal_data_memory_decoder_tb;
    logic clk_i = 1'b0, nrst_i = 1'b0, req_i = 1'b0, wr_i = 1'b0, indirect_i = 1'b0;
    logic bit_i = 1'b0, ptr_sel_i = 1'b0, wbit_i = 1'b0, push_i = 1'b0, pop_i = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, sfr_rdata_i;
    logic ack_o, rbit_o, busy_o, sfr_req_o, sfr_wr_o;
    logic [7:0] rdata_o, sfr_addr_o, sfr_wdata_o, stack_top_pointer_o;
    logic [7:0] program_status_word_o, accumulator_reg_o, b_reg_o;
    logic [1:0] bank_o;
    int n_mismatch = 0, checks = 0, cycles = 0;

    internal_data_memory_decoder u_internal_data_memory_decoder (.*);
    idm_sfr_model u_idm_sfr_model (.clk_i(clk_i), .sfr_req_i(sfr_req_o), .sfr_wr_i(sfr_wr_o),
        .sfr_addr_i(sfr_addr_o), .sfr_wdata_i(sfr_wdata_o), .sfr_rdata_o(sfr_rdata_i));

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    // Cut a hang short; the run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Wait a bounded time for the done pulse, sampled mid-cycle
    task automatic wack();
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 8);
        chk("ack", {7'h00, ack_o}, 8'h01);
    endtask : wack

    task automatic acc(input logic w, ind, bt, sel, input logic [7:0] a, d, input logic wb);
        @(posedge clk_i);
        req_i <= 1'b1;
        wr_i <= w;
        indirect_i <= ind;
        bit_i <= bt;
        ptr_sel_i <= sel;
        addr_i <= a;
        wdata_i <= d;
        wbit_i <= wb;
        @(posedge clk_i);
        req_i <= 1'b0;
        wack();
    endtask : acc

    task automatic stk(input logic p, input logic [7:0] d);
        @(posedge clk_i);
        push_i <= p;
        pop_i <= !p;
        wdata_i <= d;
        @(posedge clk_i);
        push_i <= 1'b0;
        pop_i <= 1'b0;
        wack();
    endtask : stk

    task automatic t_reset();
        chk("sp", stack_top_pointer_o, 8'h07);
        chk("acc", accumulator_reg_o, 8'h00);
        chk("b", b_reg_o, 8'h00);
        chk("bank", {6'h00, bank_o}, 8'h00);
    endtask : t_reset

    task automatic t_stack();
        stk(1'b1, 8'hA1);
        chk("sp", stack_top_pointer_o, 8'h08);
        @(posedge clk_i);
        push_i <= 1'b1;
        wdata_i <= 8'hA2;
        @(posedge clk_i);
        wdata_i <= 8'hA3;
        @(posedge clk_i);
        push_i <= 1'b0;
        wack();
        chk("sp", stack_top_pointer_o, 8'h0A);
        acc(1'b0, 1'b0, 1'b0, 1'b0, 8'h08, 8'h00, 1'b0);
        chk("ram8", rdata_o, 8'hA1);
        stk(1'b0, 8'h00);
        chk("pop", rdata_o, 8'hA3);
        chk("sp", stack_top_pointer_o, 8'h09);
        acc(1'b1, 1'b0, 1'b0, 1'b0, 8'h81, 8'hFF, 1'b0);
        stk(1'b1, 8'hB4);
        chk("sp", stack_top_pointer_o, 8'h00);
        acc(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
        chk("ram0", rdata_o, 8'hB4);
        acc(1'b0, 1'b0, 1'b0, 1'b0, 8'h81, 8'h00, 1'b0);
        chk("sp rd", rdata_o, 8'h00);
    endtask : t_stack

    task automatic t_banks();
        // Stack moved clear of the banks before they hold data
        acc(1'b1, 1'b0, 1'b0, 1'b0, 8'h81, 8'h5F, 1'b0);
        chk("sp move", stack_top_pointer_o, 8'h5F);
        for (int b = 0; b < 4; b++) begin
            acc(1'b1, 1'b0, 1'b0, 1'b0, 8'hD0, 8'(b << 3), 1'b0);
            chk("bank", {6'h00, bank_o}, 8'(b));
            chk("psw", program_status_word_o, 8'(b << 3));
            acc(1'b1, 1'b0, 1'b0, 1'b0, 8'(b * 8), 8'(8'h40 + b), 1'b0);
            acc(1'b1, 1'b0, 1'b0, 1'b0, 8'(8'h40 + b), 8'(8'hC0 + b), 1'b0);
            acc(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
            chk("ind", rdata_o, 8'(8'hC0 + b));
        end
        acc(1'b1, 1'b0, 1'b0, 1'b0, 8'h19, 8'hF2, 1'b0);
        acc(1'b1, 1'b1, 1'b0, 1'b1, 8'h00, 8'h6E, 1'b0);
        acc(1'b0, 1'b1, 1'b0, 1'b1, 8'h00, 8'h00, 1'b0);
        chk("upper", rdata_o, 8'h6E);
        acc(1'b0, 1'b0, 1'b0, 1'b0, 8'hF2, 8'h00, 1'b0);
        chk("sfr", rdata_o, 8'hF2);
    endtask : t_banks

    task automatic t_bits();
        acc(1'b1, 1'b0, 1'b0, 1'b0, 8'h22, 8'h00, 1'b0);
        acc(1'b1, 1'b0, 1'b0, 1'b0, 8'h2F, 8'h00, 1'b0);
        acc(1'b1, 1'b0, 1'b1, 1'b0, 8'h13, 8'h00, 1'b1);
        acc(1'b1, 1'b0, 1'b1, 1'b0, 8'h7F, 8'h00, 1'b1);
        acc(1'b0, 1'b0, 1'b0, 1'b0, 8'h22, 8'h00, 1'b0);
        chk("b22", rdata_o, 8'h08);
        acc(1'b0, 1'b0, 1'b0, 1'b0, 8'h2F, 8'h00, 1'b0);
        chk("b2f", rdata_o, 8'h80);
        acc(1'b1, 1'b0, 1'b0, 1'b0, 8'h13, 8'h55, 1'b0);
        acc(1'b0, 1'b0, 1'b1, 1'b0, 8'h13, 8'h00, 1'b0);
        chk("rbit", {7'h00, rbit_o}, 8'h01);
        acc(1'b0, 1'b0, 1'b0, 1'b0, 8'h13, 8'h00, 1'b0);
        chk("b13", rdata_o, 8'h55);
    endtask : t_bits

    task automatic t_sfr();
        acc(1'b1, 1'b0, 1'b1, 1'b0, 8'hE3, 8'h00, 1'b1);
        chk("acc", accumulator_reg_o, 8'h08);
        acc(1'b1, 1'b0, 1'b1, 1'b0, 8'h9A, 8'h00, 1'b1);
        acc(1'b0, 1'b0, 1'b0, 1'b0, 8'h98, 8'h00, 1'b0);
        chk("x98", rdata_o, 8'h9C);
        acc(1'b1, 1'b0, 1'b0, 1'b0, 8'h83, 8'h21, 1'b0);
        chk("addr", sfr_addr_o, 8'h83);
        chk("wdat", sfr_wdata_o, 8'h21);
        acc(1'b1, 1'b0, 1'b0, 1'b0, 8'hF0, 8'h5A, 1'b0);
        chk("b", b_reg_o, 8'h5A);
    endtask : t_sfr

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // Reset for eight cycles, then the scenarios
    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(negedge clk_i);
        t_reset();
        t_stack();
        t_banks();
        t_bits();
        t_sfr();
        conclude();
    end
endmodule : internal_data_memory_decoder_tb
